// *** rtl/ttcsr_pkg.sv ***
// Package: addresses, field layouts, reset values and carriers of the trap/trigger CSR bank
package ttcsr_pkg;

    // CSR addresses
    localparam logic [11:0] ADDR_SCRATCH   = 12'h340;
    localparam logic [11:0] ADDR_RET_PC    = 12'h341;
    localparam logic [11:0] ADDR_CAUSE     = 12'h342;
    localparam logic [11:0] ADDR_TVAL      = 12'h343;
    localparam logic [11:0] ADDR_PENDING   = 12'h344;
    localparam logic [11:0] ADDR_TSELECT   = 12'h7a0;
    localparam logic [11:0] ADDR_TCONTROL  = 12'h7a1;
    localparam logic [11:0] ADDR_TMATCH    = 12'h7a2;
    localparam logic [11:0] ADDR_TAUX      = 12'h7a3;
    localparam logic [11:0] ADDR_TINFO     = 12'h7a4;
    localparam logic [11:0] ADDR_MCONTEXT  = 12'h7a8;

    // Reset values
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
    localparam logic [31:0] RST_TCONTROL   = 32'h2800_1040;
    localparam logic [31:0] TINFO_VALUE    = 32'h0000_0004;

    // Field layout
    localparam int          CAUSE_IRQ_BIT  = 31;
    localparam int          CAUSE_CODE_W   = 5;
    localparam int          TCTRL_EXEC_BIT = 2;
    localparam logic [31:0] PEND_MASK      = 32'hffff_0888;
    localparam logic [31:0] RET_PC_MASK    = 32'hffff_fffe;

    // Privilege level of machine mode
    localparam logic [1:0]  PRIV_MACHINE   = 2'h3;

    // CSR operation codes
    typedef enum logic [1:0] {
        TTCSR_OP_READ  = 2'b00,
        TTCSR_OP_WRITE = 2'b01,
        TTCSR_OP_SET   = 2'b10,
        TTCSR_OP_CLEAR = 2'b11
    } ttcsr_op_e;

    typedef struct packed {
        logic        valid;
        ttcsr_op_e   op;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ttcsr_req_s;

    typedef struct packed {
        logic        take;
        logic        is_irq;
        logic [4:0]  code;
        logic [31:0] pc;
    } ttcsr_trap_s;

endpackage : ttcsr_pkg

// *** rtl/ttcsr_bank.sv ***
// Trap and trigger CSR bank of the core
`timescale 1ns/1ns
`default_nettype none

module ttcsr_bank (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire ttcsr_pkg::ttcsr_req_s csr_req,
    output logic [31:0]               csr_rdata,
    output logic                      csr_illegal,
    input  wire logic [1:0]           priv_level,
    input  wire logic                 debug_mode,
    input  wire ttcsr_pkg::ttcsr_trap_s trap_in,
    input  wire logic                 mret_exec,
    input  wire logic [31:0]          handler_addr,
    output logic                      pc_redirect,
    output logic [31:0]               pc_target,
    input  wire logic                 instr_valid,
    input  wire logic [31:0]          instr_addr,
    output logic                      trigger_hit,
    input  wire logic [31:0]          irq_lines
);

    // ------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------
    logic        rst_s1_q;
    logic        rst_n_q;
    logic [31:0] irq_s1_q;
    logic [31:0] irq_s2_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Request lines come from outside the core clock
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_s1_q <= ttcsr_pkg::RST_ZERO;
            irq_s2_q <= ttcsr_pkg::RST_ZERO;
        end else begin
            irq_s1_q <= irq_lines;
            irq_s2_q <= irq_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    function automatic logic [31:0] csr_apply(input ttcsr_pkg::ttcsr_op_e op,
                                              input logic [31:0] old_v,
                                              input logic [31:0] wd);
        unique case (op)
            ttcsr_pkg::TTCSR_OP_WRITE: csr_apply = wd;
            ttcsr_pkg::TTCSR_OP_SET:   csr_apply = old_v | wd;
            ttcsr_pkg::TTCSR_OP_CLEAR: csr_apply = old_v & ~wd;
            ttcsr_pkg::TTCSR_OP_READ:  csr_apply = old_v;
        endcase
    endfunction : csr_apply

    logic [31:0] scratch_q;
    logic [31:0] scratch_d;
    logic [31:0] ret_pc_q;
    logic [31:0] ret_pc_d;
    logic        cause_irq_q;
    logic        cause_irq_d;
    logic [4:0]  cause_code_q;
    logic [4:0]  cause_code_d;
    logic        exec_en_q;
    logic        exec_en_d;
    logic [31:0] tmatch_q;
    logic [31:0] tmatch_d;

    wire logic        acc       = csr_req.valid;
    wire logic        wr_op     = csr_req.op != ttcsr_pkg::TTCSR_OP_READ;
    wire logic        is_trig   = csr_req.addr[11:4] == ttcsr_pkg::ADDR_TSELECT[11:4];
    wire logic        trig_priv = debug_mode || priv_level == ttcsr_pkg::PRIV_MACHINE;
    wire logic        hit_known;
    wire logic        wr_ok     = acc && wr_op && !csr_illegal;
    wire logic        trig_wr   = wr_ok && debug_mode;
    wire logic [31:0] cause_rd  = {cause_irq_q, 26'h0, cause_code_q};
    wire logic [31:0] tctrl_rd  = ttcsr_pkg::RST_TCONTROL |
                                  {29'h0, exec_en_q, 2'h0};

    always_comb begin
        csr_rdata = ttcsr_pkg::RST_ZERO;
        unique case (csr_req.addr)
            ttcsr_pkg::ADDR_SCRATCH:  csr_rdata = scratch_q;
            ttcsr_pkg::ADDR_RET_PC:   csr_rdata = ret_pc_q;
            ttcsr_pkg::ADDR_CAUSE:    csr_rdata = cause_rd;
            ttcsr_pkg::ADDR_TVAL:     csr_rdata = ttcsr_pkg::RST_ZERO;
            ttcsr_pkg::ADDR_PENDING:  csr_rdata = irq_s2_q & ttcsr_pkg::PEND_MASK;
            ttcsr_pkg::ADDR_TSELECT:  csr_rdata = ttcsr_pkg::RST_ZERO;
            ttcsr_pkg::ADDR_TCONTROL: csr_rdata = tctrl_rd;
            ttcsr_pkg::ADDR_TMATCH:   csr_rdata = tmatch_q;
            ttcsr_pkg::ADDR_TAUX:     csr_rdata = ttcsr_pkg::RST_ZERO;
            ttcsr_pkg::ADDR_TINFO:    csr_rdata = ttcsr_pkg::TINFO_VALUE;
            ttcsr_pkg::ADDR_MCONTEXT: csr_rdata = ttcsr_pkg::RST_ZERO;
            default:                  csr_rdata = ttcsr_pkg::RST_ZERO;
        endcase
    end

    assign hit_known = csr_req.addr inside {ttcsr_pkg::ADDR_SCRATCH, ttcsr_pkg::ADDR_RET_PC,
        ttcsr_pkg::ADDR_CAUSE, ttcsr_pkg::ADDR_TVAL, ttcsr_pkg::ADDR_PENDING,
        ttcsr_pkg::ADDR_TSELECT, ttcsr_pkg::ADDR_TCONTROL, ttcsr_pkg::ADDR_TMATCH,
        ttcsr_pkg::ADDR_TAUX, ttcsr_pkg::ADDR_TINFO, ttcsr_pkg::ADDR_MCONTEXT};

    // Unknown addresses are left to the rest of the CSR file, so not flagged here
    assign csr_illegal = acc && hit_known && is_trig && !trig_priv;

    wire logic [31:0] wval = csr_apply(csr_req.op, csr_rdata, csr_req.wdata);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    wire logic sel_scr  = wr_ok && csr_req.addr == ttcsr_pkg::ADDR_SCRATCH;
    wire logic sel_rpc  = wr_ok && csr_req.addr == ttcsr_pkg::ADDR_RET_PC;
    wire logic sel_cau  = wr_ok && csr_req.addr == ttcsr_pkg::ADDR_CAUSE;
    wire logic sel_tct  = trig_wr && csr_req.addr == ttcsr_pkg::ADDR_TCONTROL;
    wire logic sel_tma  = trig_wr && csr_req.addr == ttcsr_pkg::ADDR_TMATCH;

    // A trap in the same cycle as a software write wins: hardware state is newer
    assign scratch_d    = sel_scr ? wval : scratch_q;
    assign ret_pc_d     = trap_in.take ? (trap_in.pc & ttcsr_pkg::RET_PC_MASK)
                        : sel_rpc ? (wval & ttcsr_pkg::RET_PC_MASK) : ret_pc_q;
    assign cause_irq_d  = trap_in.take ? trap_in.is_irq
                        : sel_cau ? wval[ttcsr_pkg::CAUSE_IRQ_BIT] : cause_irq_q;
    assign cause_code_d = trap_in.take ? trap_in.code
                        : sel_cau ? wval[ttcsr_pkg::CAUSE_CODE_W-1:0] : cause_code_q;
    assign exec_en_d    = sel_tct ? wval[ttcsr_pkg::TCTRL_EXEC_BIT] : exec_en_q;
    assign tmatch_d     = sel_tma ? wval : tmatch_q;

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scratch_q    <= ttcsr_pkg::RST_ZERO;
            ret_pc_q     <= ttcsr_pkg::RST_ZERO;
            cause_irq_q  <= 1'b0;
            cause_code_q <= 5'h00;
            exec_en_q    <= 1'b0;
            tmatch_q     <= ttcsr_pkg::RST_ZERO;
        end else begin
            scratch_q    <= scratch_d;
            ret_pc_q     <= ret_pc_d;
            cause_irq_q  <= cause_irq_d;
            cause_code_q <= cause_code_d;
            exec_en_q    <= exec_en_d;
            tmatch_q     <= tmatch_d;
        end
    end

    // ------------------------------------------------------------
    // Fetch redirect and breakpoint
    // ------------------------------------------------------------
    logic        redir_q;
    logic [31:0] target_q;
    logic        hit_q;

    // Compared before execution so the core can break ahead of the instruction
    wire logic hit_d = instr_valid && exec_en_q && !debug_mode
                       && instr_addr == tmatch_q;

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            redir_q  <= 1'b0;
            target_q <= ttcsr_pkg::RST_ZERO;
            hit_q    <= 1'b0;
        end else begin
            redir_q  <= trap_in.take || mret_exec;
            target_q <= trap_in.take ? handler_addr
                      : mret_exec ? ret_pc_q : target_q;
            hit_q    <= hit_d;
        end
    end

    assign pc_redirect = redir_q;
    assign pc_target   = target_q;
    assign trigger_hit = hit_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_q);

    // ------------------------------------------------------------
    // Trap registers and fetch redirect
    // ------------------------------------------------------------

    a_ret_pc_lsb: assert property (
        ret_pc_q[0] == 1'b0)
        else $error("return pc bit 0 set");

    a_ret_pc_write: assert property (
        sel_rpc && !trap_in.take |=> ret_pc_q == ($past(wval) & ttcsr_pkg::RET_PC_MASK))
        else $error("return pc write not stored");

    a_trap_saves_pc: assert property (
        trap_in.take |=> ret_pc_q[31:1] == $past(trap_in.pc[31:1])
        && pc_redirect && pc_target == $past(handler_addr))
        else $error("trap did not save pc or redirect");

    a_redir_pulse: assert property (
        !trap_in.take && !mret_exec |=> !pc_redirect)
        else $error("redirect without trap or mret");

    // Trap and mret together: the trap must win the fetch target
    a_trap_prio: assert property (
        trap_in.take && mret_exec |=> pc_target == $past(handler_addr))
        else $error("mret overrode a trap");

    a_mret_target: assert property (
        mret_exec && !trap_in.take |=> pc_redirect && pc_target == $past(ret_pc_q))
        else $error("mret target wrong");

    a_cause_irq: assert property (
        trap_in.take |=> cause_irq_q == $past(trap_in.is_irq)
        && cause_code_q == $past(trap_in.code))
        else $error("cause not captured");

    a_cause_write: assert property (
        sel_cau && !trap_in.take |=> cause_irq_q == $past(wval[ttcsr_pkg::CAUSE_IRQ_BIT]))
        else $error("cause interrupt bit write lost");

    a_cause_code_wr: assert property (
        sel_cau && !trap_in.take |=> cause_code_q == $past(wval[ttcsr_pkg::CAUSE_CODE_W-1:0]))
        else $error("cause code write lost");

    a_cause_zero: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_CAUSE |-> csr_rdata[30:5] == 26'h0)
        else $error("cause reserved bits set");

    a_scratch_write: assert property (
        sel_scr |=> scratch_q == $past(wval))
        else $error("scratch write not stored");

    a_scratch_hold: assert property (
        !sel_scr |=> $stable(scratch_q))
        else $error("scratch changed without a write");

    // ------------------------------------------------------------
    // Read-only and fixed views
    // ------------------------------------------------------------

    a_tval_zero: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TVAL |-> csr_rdata == 32'h0)
        else $error("trap value not zero");

    a_pend_mirror: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_PENDING |->
        csr_rdata == ($past(irq_lines, 2) & ttcsr_pkg::PEND_MASK))
        else $error("pending does not mirror lines");

    a_pend_low_zero: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_PENDING |->
        (csr_rdata & ~ttcsr_pkg::PEND_MASK) == ttcsr_pkg::RST_ZERO)
        else $error("pending unused bits set");

    a_tsel_zero: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TSELECT |-> csr_rdata == ttcsr_pkg::RST_ZERO)
        else $error("trigger select not zero");

    a_tctrl_fixed: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TCONTROL |->
        csr_rdata[31:3] == 29'h0500_0208 && csr_rdata[1:0] == 2'h0)
        else $error("trigger control fixed fields wrong");

    a_aux_zero: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TAUX |-> csr_rdata == ttcsr_pkg::RST_ZERO)
        else $error("aux data not zero");

    a_ctx_zero: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_MCONTEXT |-> csr_rdata == ttcsr_pkg::RST_ZERO)
        else $error("context not zero");

    a_tinfo_fixed: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TINFO |-> csr_rdata == ttcsr_pkg::TINFO_VALUE)
        else $error("type info wrong");

    // ------------------------------------------------------------
    // Trigger storage and matching
    // ------------------------------------------------------------

    a_mmode_no_wr: assert property (
        acc && wr_op && !debug_mode && csr_req.addr == ttcsr_pkg::ADDR_TMATCH
        |=> $stable(tmatch_q))
        else $error("machine mode changed match address");

    a_ctrl_mmode: assert property (
        acc && wr_op && !debug_mode && csr_req.addr == ttcsr_pkg::ADDR_TCONTROL
        |=> $stable(exec_en_q))
        else $error("machine mode changed execute bit");

    a_exec_hold: assert property (
        !sel_tct |=> $stable(exec_en_q))
        else $error("execute bit changed without a write");

    a_tctrl_exec: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TCONTROL |->
        csr_rdata[ttcsr_pkg::TCTRL_EXEC_BIT] == exec_en_q)
        else $error("execute bit not reported");

    a_hit_cause: assert property (
        trigger_hit |-> $past(exec_en_q) && $past(instr_addr) == $past(tmatch_q))
        else $error("trigger fired without match");

    a_hit_fires: assert property (
        instr_valid && exec_en_q && !debug_mode && instr_addr == tmatch_q
        |=> trigger_hit)
        else $error("trigger missed a match");

    // Already halted: a second break would re-enter debug on its own code
    a_hit_debug: assert property (
        debug_mode |=> !trigger_hit)
        else $error("trigger fired in debug mode");

    a_tmatch_write: assert property (
        sel_tma |=> tmatch_q == $past(wval))
        else $error("match address write lost");

    a_tmatch_read: assert property (
        csr_req.addr == ttcsr_pkg::ADDR_TMATCH |-> csr_rdata == tmatch_q)
        else $error("match address read wrong");

    // ------------------------------------------------------------
    // Access rights
    // ------------------------------------------------------------

    a_trig_priv: assert property (
        acc && is_trig && hit_known && !trig_priv |-> csr_illegal)
        else $error("low privilege trigger access not flagged");

    a_legal_priv: assert property (
        acc && trig_priv |-> !csr_illegal)
        else $error("privileged access flagged illegal");

    a_illegal_src: assert property (
        csr_illegal |-> acc && is_trig)
        else $error("illegal flag outside trigger map");

    a_illegal_nowr: assert property (
        csr_illegal |=> $stable(tmatch_q) && $stable(exec_en_q))
        else $error("illegal access changed trigger state");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------

    c_trap:    cover property (trap_in.take ##1 mret_exec);
    c_hit:     cover property (trigger_hit);
    c_illegal: cover property (csr_illegal);
    c_tmatch:  cover property (sel_tma);
    c_set_op:  cover property (wr_ok && csr_req.op == ttcsr_pkg::TTCSR_OP_SET);

endmodule : ttcsr_bank

`default_nettype wire

// *** dv/ttcsr_irq_model.sv ***
// Behavioural model of the interrupt request lines that feed the CSR bank
`timescale 1ns/1ns
`default_nettype none

module ttcsr_irq_model (
    input  wire logic        mclk,
    output logic [31:0]      irq_lines
);
    logic [31:0] next_lines = 32'h0000_0000;

    initial irq_lines = 32'h0000_0000;

    // Lines move only just after an edge, like a synchronous source would
    always @(posedge mclk) irq_lines <= next_lines;

    task automatic set_irq(input logic [31:0] v);
        next_lines = v;
    endtask : set_irq
endmodule : ttcsr_irq_model

`default_nettype wire

// *** dv/trap_and_trigger_csr_bank_bench.sv ***
// Self-checking bench of the trap and trigger CSR bank
`timescale 1ns/1ns
`default_nettype none

module trap_and_trigger_csr_bank_bench;
    logic                    mclk = 1'b0;
    logic                    nrst = 1'b0;
    ttcsr_pkg::ttcsr_req_s   csr_req = '0;
    ttcsr_pkg::ttcsr_trap_s  trap_in = '0;
    logic [31:0]             csr_rdata;
    logic                    csr_illegal;
    logic [1:0]              priv_level = 2'h3;
    logic                    debug_mode = 1'b0;
    logic                    mret_exec = 1'b0;
    logic [31:0]             handler_addr = 32'h0000_0000;
    logic                    pc_redirect;
    logic [31:0]             pc_target;
    logic                    instr_valid = 1'b0;
    logic [31:0]             instr_addr = 32'h0000_0000;
    logic                    trigger_hit;
    logic [31:0]             irq_lines;
    int                      n_errors = 0;
    int                      checked = 0;
    int                      cycles = 0;

    always #25 mclk = ~mclk;

    ttcsr_bank u_dut (.mclk(mclk), .nrst(nrst), .csr_req(csr_req), .csr_rdata(csr_rdata),
        .csr_illegal(csr_illegal), .priv_level(priv_level), .debug_mode(debug_mode),
        .trap_in(trap_in), .mret_exec(mret_exec), .handler_addr(handler_addr),
        .pc_redirect(pc_redirect), .pc_target(pc_target), .instr_valid(instr_valid),
        .instr_addr(instr_addr), .trigger_hit(trigger_hit), .irq_lines(irq_lines));

    ttcsr_irq_model u_core (.mclk(mclk), .irq_lines(irq_lines));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (n_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // Read data is combinational, so it is judged at the falling edge
    task automatic acc(input ttcsr_pkg::ttcsr_op_e op, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        csr_req <= '{valid: 1'b1, op: op, addr: a, wdata: d};
        @(negedge mclk);
    endtask : acc

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        acc(ttcsr_pkg::TTCSR_OP_READ, a, 32'h0000_0000);
        cmp(csr_rdata, exp);
    endtask : rd

    task automatic mod(input ttcsr_pkg::ttcsr_op_e op, input logic [11:0] a,
                       input logic [31:0] d);
        acc(op, a, d);
        @(posedge mclk);
        csr_req.valid <= 1'b0;
    endtask : mod

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        mod(ttcsr_pkg::TTCSR_OP_WRITE, a, d);
    endtask : wr

    task automatic pulse_check(input logic [31:0] target);
        @(negedge mclk);
        cmp({31'h0, pc_redirect}, 32'h1);
        cmp(pc_target, target);
        @(negedge mclk);
        cmp({31'h0, pc_redirect}, 32'h0);
    endtask : pulse_check

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_software_regs;
        rd(12'h7a1, 32'h2800_1040);
        rd(12'h7a4, 32'h0000_0004);
        wr(12'h340, 32'ha5a5_5a5b);
        wr(12'h341, 32'hffff_ffff);
        wr(12'h342, 32'hffff_ffeb);
        wr(12'h343, 32'hffff_ffff);
        wr(12'h7a0, 32'hffff_ffff);
        wr(12'h7a3, 32'hffff_ffff);
        wr(12'h7a8, 32'hffff_ffff);
        wr(12'h7a4, 32'h0000_0000);
        wr(12'h7a1, 32'h0000_0004);
        wr(12'h7a2, 32'h1234_5678);
        rd(12'h340, 32'ha5a5_5a5b);
        rd(12'h341, 32'hffff_fffe);
        rd(12'h342, 32'h8000_000b);
        rd(12'h343, 32'h0000_0000);
        rd(12'h7a0, 32'h0000_0000);
        rd(12'h7a3, 32'h0000_0000);
        rd(12'h7a8, 32'h0000_0000);
        rd(12'h7a4, 32'h0000_0004);
        rd(12'h7a1, 32'h2800_1040);
        rd(12'h7a2, 32'h0000_0000);
        cmp({31'h0, csr_illegal}, 32'h0);
    endtask : sc_software_regs

    task automatic sc_low_privilege;
        @(posedge mclk) priv_level <= 2'h0;
        rd(12'h7a4, 32'h0000_0004);
        cmp({31'h0, csr_illegal}, 32'h1);
        rd(12'h340, 32'ha5a5_5a5b);
        cmp({31'h0, csr_illegal}, 32'h0);
        @(posedge mclk) priv_level <= 2'h3;
    endtask : sc_low_privilege

    task automatic sc_trap_and_return;
        @(posedge mclk);
        trap_in <= '{take: 1'b1, is_irq: 1'b1, code: 5'h07, pc: 32'h0000_1235};
        handler_addr <= 32'h0000_2000;
        @(posedge mclk) trap_in.take <= 1'b0;
        pulse_check(32'h0000_2000);
        rd(12'h341, 32'h0000_1234);
        rd(12'h342, 32'h8000_0007);
        @(posedge mclk) trap_in <= '{take: 1'b1, is_irq: 1'b0, code: 5'h02, pc: 32'h0000_4440};
        @(posedge mclk) trap_in.take <= 1'b0;
        pulse_check(32'h0000_2000);
        rd(12'h342, 32'h0000_0002);
        @(posedge mclk) mret_exec <= 1'b1;
        @(posedge mclk) mret_exec <= 1'b0;
        pulse_check(32'h0000_4440);
    endtask : sc_trap_and_return

    // Set and clear ops, then a trap landing on a return pc write
    task automatic sc_set_and_priority;
        mod(ttcsr_pkg::TTCSR_OP_SET, 12'h340, 32'h0000_0004);
        rd(12'h340, 32'ha5a5_5a5f);
        mod(ttcsr_pkg::TTCSR_OP_CLEAR, 12'h340, 32'ha5a5_0000);
        rd(12'h340, 32'h0000_5a5f);
        @(posedge mclk);
        csr_req <= '{valid: 1'b1, op: ttcsr_pkg::TTCSR_OP_WRITE,
                     addr: 12'h341, wdata: 32'hffff_0000};
        trap_in <= '{take: 1'b1, is_irq: 1'b0, code: 5'h03, pc: 32'h0000_0601};
        @(posedge mclk);
        csr_req.valid <= 1'b0;
        trap_in.take <= 1'b0;
        pulse_check(32'h0000_2000);
        rd(12'h341, 32'h0000_0600);
    endtask : sc_set_and_priority

    task automatic fetch(input logic [31:0] a, input logic [31:0] exp_hit);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_addr <= a;
        @(posedge mclk) instr_valid <= 1'b0;
        @(negedge mclk) cmp({31'h0, trigger_hit}, exp_hit);
    endtask : fetch

    task automatic sc_trigger;
        @(posedge mclk) debug_mode <= 1'b1;
        wr(12'h7a2, 32'h8000_0100);
        wr(12'h7a1, 32'hffff_ffff);
        rd(12'h7a1, 32'h2800_1044);
        rd(12'h7a2, 32'h8000_0100);
        fetch(32'h8000_0100, 32'h0);
        @(posedge mclk) debug_mode <= 1'b0;
        fetch(32'h8000_0100, 32'h1);
        fetch(32'h0000_0100, 32'h0);
        wr(12'h7a1, 32'h0000_0000);
        fetch(32'h8000_0100, 32'h1);
    endtask : sc_trigger

    task automatic sc_pending;
        u_core.set_irq(32'hffff_ffff);
        repeat (4) @(posedge mclk);
        rd(12'h344, 32'hffff_0888);
        u_core.set_irq(32'h0001_0080);
        repeat (4) @(posedge mclk);
        rd(12'h344, 32'h0001_0080);
        u_core.set_irq(32'h0000_0808);
        repeat (4) @(posedge mclk);
        rd(12'h344, 32'h0000_0808);
    endtask : sc_pending

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        sc_software_regs();
        sc_low_privilege();
        sc_trap_and_return();
        sc_set_and_priority();
        sc_trigger();
        sc_pending();
        tally_and_finish();
    end
endmodule : trap_and_trigger_csr_bank_bench

`default_nettype wire
